// ===== bench/tcf_scanner_model.sv
// controller scanner model: paced four-byte word reads
`timescale 1ns/10ps
`default_nettype none
module tcf_scanner_model (
    // clock and command
    input wire logic clk_in,
    input wire logic go_in,
    // byte bus
    input wire logic [7:0] rd_data_in,
    output logic rd_strobe_out,
    output logic [1:0] rd_byte_sel_out,
    // result
    output logic [31:0] word_out,
    output logic done_out
);
    // backplane positions 1 and 2 of the slot; closed reads as zero
    localparam logic [1:0] SLOT_SW_LOW = 2'h0;
    int burst;
    initial begin
        rd_strobe_out = 1'b0;
        rd_byte_sel_out = 2'h3;
        word_out = 32'h0000_0000;
        done_out = 1'b0;
        burst = 0;
        forever begin
            @(posedge clk_in);
            done_out <= 1'b0;
            if (go_in && SLOT_SW_LOW == 2'h0) begin
                // fastest legal pacing: each scan at the minimum spacing, with a rest after every full burst
                repeat (tcf_pkg::SCAN_MIN_CYC) @(posedge clk_in);
                if (burst == tcf_pkg::SCAN_BURST_MAX) begin
                    repeat (tcf_pkg::SCAN_REST_CYC) @(posedge clk_in);
                    burst = 0;
                end
                burst++;
                rd_strobe_out <= 1'b1;
                rd_byte_sel_out <= 2'h0;
                // each byte stands from the edge after its strobe until the next strobe edge
                for (int k = 0; k < 5; k++) begin
                    @(posedge clk_in);
                    if (k > 0) begin
                        word_out[8*(k-1) +: 8] <= rd_data_in;
                    end
                    rd_strobe_out <= (k < 3);
                    rd_byte_sel_out <= (k < 3) ? 2'(k + 1) : 2'h3;
                end
                done_out <= 1'b1;
            end
        end
    end
endmodule : tcf_scanner_model
`default_nettype wire

// ===== bench/test_tcf_scan_word.sv
// self-checking bench for the thermocouple scan word formatter
`timescale 1ns/10ps
`default_nettype none
module test_tcf_scan_word;
    typedef struct packed {
        logic [2:0] ty;
        logic signed [12:0] t;
        logic fmt;
        logic un;
        logic ov;
    } tcf_row_t;
    logic clk_in, rst_n_in, rd_strobe, sample_wr_in, sample_open_in, board_ok_in, fmt_twos_in, go, done, hb;
    logic [1:0] rd_byte_sel;
    logic [7:0] rd_data_out;
    logic [2:0] sample_chan_in, tc_type_in, chan_ptr_out, exp_ptr;
    logic signed [12:0] sample_temp_in;
    logic signed [7:0] cj_temp_in;
    logic [31:0] word;
    int num_errors, checked;
    tcf_row_t rows [8] = '{'{3'h0, -13'sh015A, 1'b1, 1'b1, 1'b0}, '{3'h1, 13'sh09C4, 1'b0, 1'b0, 1'b1},
        '{3'h2, 13'sh0021, 1'b1, 1'b0, 1'b0}, '{3'h3, -13'sh01C6, 1'b0, 1'b1, 1'b0},
        '{3'h4, 13'sh0CEC, 1'b1, 1'b0, 1'b1}, '{3'h5, -13'sh01C5, 1'b0, 1'b0, 1'b0},
        '{3'h6, -13'sh003A, 1'b1, 1'b1, 1'b0}, '{3'h7, 13'sh0C8D, 1'b0, 1'b0, 1'b0}};
    logic signed [7:0] cjs [4] = '{-8'sh01, 8'sh00, 8'sh3C, 8'sh3D};

    tcf_scan_word dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .rd_strobe_in(rd_strobe),
        .rd_byte_sel_in(rd_byte_sel), .rd_data_out(rd_data_out), .sample_wr_in(sample_wr_in),
        .sample_chan_in(sample_chan_in), .sample_temp_in(sample_temp_in), .sample_open_in(sample_open_in),
        .cj_temp_in(cj_temp_in), .board_ok_in(board_ok_in), .tc_type_in(tc_type_in),
        .fmt_twos_in(fmt_twos_in), .chan_ptr_out(chan_ptr_out));
    tcf_scanner_model host (.clk_in(clk_in), .go_in(go), .rd_data_in(rd_data_out), .rd_strobe_out(rd_strobe),
        .rd_byte_sel_out(rd_byte_sel), .word_out(word), .done_out(done));

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        checked++;
        if ((got & mask) !== (exp & mask)) begin
            num_errors++;
            $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_ptr(input logic [2:0] got, input logic [2:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: pointer %h expected %h", $time, got, exp);
        end
    endtask : check_ptr

    // expected word from the field layout; magnitude saturates at twelve bits
    function automatic logic [31:0] expect_word(input logic v, input logic un, input logic ov, input logic fmt,
        input logic signed [12:0] t);
        logic [31:0] w;
        int a;
        a = (t < 0) ? -int'(t) : int'(t);
        if (a > 4095) a = 4095;
        w = 32'h0000_0000;
        w[2:0] = exp_ptr;
        w[8] = v;
        w[10] = sample_open_in;
        w[12] = board_ok_in;
        w[13] = un;
        w[14] = ov;
        w[15] = hb;
        if (fmt) begin
            w[31:16] = {{4{t[12]}}, t[11:0]};
        end else begin
            w[27:16] = a[11:0];
            w[11] = t[12];
        end
        return w;
    endfunction : expect_word

    task automatic load(input logic [2:0] ch, input logic signed [12:0] t);
        sample_wr_in <= 1'b1;
        sample_chan_in <= ch;
        sample_temp_in <= t;
        @(posedge clk_in);
        sample_wr_in <= 1'b0;
        @(posedge clk_in);
    endtask : load

    task automatic scan(input logic v, input logic un, input logic ov, input logic fmt,
        input logic signed [12:0] t, input logic [31:0] mask);
        logic [31:0] exp;
        exp = expect_word(v, un, ov, fmt, t);
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk_in);
            if (done === 1'b1) begin
                check_word(word, exp, mask);
                exp_ptr = exp_ptr + 3'h1;
                hb = ~hb;
                check_ptr(chan_ptr_out, exp_ptr);
                return;
            end
        end
        num_errors++;
        $display("CHECK FAILED at %0t: read timed out", $time);
        tally_and_finish();
    endtask : scan

    initial begin
        {rst_n_in, go, sample_wr_in, sample_chan_in, sample_temp_in, sample_open_in, tc_type_in} = '0;
        {cj_temp_in, board_ok_in, fmt_twos_in, exp_ptr, hb, num_errors, checked} = {8'sh1E, 2'h3, 3'h0, 1'b0, 64'h0};
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        check_ptr(chan_ptr_out, 3'h0);
        check_word({24'h00_0000, rd_data_out}, 32'h0000_0000, 32'h0000_00FF);
        // a channel never written reports invalid
        scan(1'b0, 1'b0, 1'b0, 1'b1, 13'sh0000, 32'h0000_01FF);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            tc_type_in <= rows[i].ty;
            fmt_twos_in <= rows[i].fmt;
            sample_open_in <= i[0];
            board_ok_in <= (i < 6);
            load(exp_ptr, rows[i].t);
            scan(1'b1, rows[i].un, rows[i].ov, rows[i].fmt, rows[i].t,
                32'hFFFF_FFFF);
        end
        $display("test table done");
        for (int i = 0; i < 4; i++) begin
            cj_temp_in <= cjs[i];
            load(exp_ptr, 13'sh0064);
            check_ptr(chan_ptr_out, exp_ptr);
            scan(i == 1 || i == 2, 1'b0, 1'b0, fmt_twos_in, 13'sh0064, 32'hFFFF_FFFF);
        end
        $display("test cold junction done");
        cj_temp_in <= 8'sh1E;
        load(exp_ptr, 13'sh0064);
        // writes held across the read keep the channel updating while the word is taken
        sample_wr_in <= 1'b1;
        scan(1'b0, 1'b0, 1'b0, fmt_twos_in, 13'sh0064, 32'h0000_01FF);
        sample_wr_in <= 1'b0;
        @(posedge clk_in);
        load(exp_ptr, 13'sh0064);
        scan(1'b1, 1'b0, 1'b0, fmt_twos_in, 13'sh0064, 32'hFFFF_FFFF);
        $display("test update done");
        tally_and_finish();
    end
endmodule : test_tcf_scan_word
`default_nettype wire

// ===== rtl/tcf_pkg.sv
// shared constants for the thermocouple scan word formatter
package tcf_pkg;
    localparam int NUM_CHANNELS = 8;
    localparam int CHAN_W = 3;
    localparam int TEMP_W = 13;
    localparam int DATA_W = 12;
    localparam int WORD_W = 32;
    localparam int BYTE_W = 8;

    // word bit positions (zero based: printed bit n sits at n-1)
    localparam int POS_CHAN = 0;
    localparam int POS_VALID = 8;
    localparam int POS_UNUSED = 9;
    localparam int POS_OPEN = 10;
    localparam int POS_SIGN = 11;
    localparam int POS_BOARD_OK = 12;
    localparam int POS_UNDER = 13;
    localparam int POS_OVER = 14;
    localparam int POS_HEARTBEAT = 15;
    localparam int POS_DATA = 16;
    localparam int POS_EXT = 28;
    localparam int EXT_W = 4;

    // byte lanes of one word read
    localparam logic [1:0] BYTE_FIRST = 2'h0;
    localparam logic [1:0] BYTE_LAST = 2'h3;

    // cold junction window in degrees C
    localparam logic signed [7:0] CJ_MIN_C = 8'sh00;
    localparam logic signed [7:0] CJ_MAX_C = 8'sh3C;

    // scan pacing kept by the controller
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCAN_MIN_US = 80;
    localparam int SCAN_BURST_MAX = 8;
    localparam int SCAN_REST_US = 20;
    localparam int SCAN_MIN_CYC = (SCAN_MIN_US * 1000) / CLK_PERIOD_NS;
    localparam int SCAN_REST_CYC = (SCAN_REST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [DATA_W-1:0] MAG_MAX = 12'hFFF;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;

    typedef enum logic [2:0] {
        TCF_TYPE_J,
        TCF_TYPE_K,
        TCF_TYPE_S,
        TCF_TYPE_T,
        TCF_TYPE_B,
        TCF_TYPE_E,
        TCF_TYPE_R
    } tcf_tc_type_t;

    // range limits in degrees F
    localparam logic signed [TEMP_W-1:0] UNDER_J = -13'sd346;
    localparam logic signed [TEMP_W-1:0] UNDER_K = -13'sd350;
    localparam logic signed [TEMP_W-1:0] UNDER_S = 13'sd32;
    localparam logic signed [TEMP_W-1:0] UNDER_T = -13'sd454;
    localparam logic signed [TEMP_W-1:0] UNDER_B = 13'sd410;
    localparam logic signed [TEMP_W-1:0] UNDER_E = -13'sd454;
    localparam logic signed [TEMP_W-1:0] UNDER_R = -13'sd58;
    localparam logic signed [TEMP_W-1:0] OVER_J = 13'sd1400;
    localparam logic signed [TEMP_W-1:0] OVER_K = 13'sd2500;
    localparam logic signed [TEMP_W-1:0] OVER_S = 13'sd3214;
    localparam logic signed [TEMP_W-1:0] OVER_T = 13'sd752;
    localparam logic signed [TEMP_W-1:0] OVER_B = 13'sd3308;
    localparam logic signed [TEMP_W-1:0] OVER_E = 13'sd1832;
    localparam logic signed [TEMP_W-1:0] OVER_R = 13'sd3214;
endpackage : tcf_pkg

// ===== rtl/tcf_range_check.sv
// under and over range detection per thermocouple type
`timescale 1ns/10ps
`default_nettype none
module tcf_range_check (
    // reading
    input wire logic [2:0] tc_type_in,
    input wire logic signed [12:0] temp_in,
    // flags
    output logic under_out,
    output logic over_out
);
    logic signed [12:0] low_limit;
    logic signed [12:0] high_limit;

    always_comb begin
        case (tc_type_in)
            tcf_pkg::TCF_TYPE_J: begin
                low_limit = tcf_pkg::UNDER_J;
                high_limit = tcf_pkg::OVER_J;
            end
            tcf_pkg::TCF_TYPE_K: begin
                low_limit = tcf_pkg::UNDER_K;
                high_limit = tcf_pkg::OVER_K;
            end
            tcf_pkg::TCF_TYPE_S: begin
                low_limit = tcf_pkg::UNDER_S;
                high_limit = tcf_pkg::OVER_S;
            end
            tcf_pkg::TCF_TYPE_T: begin
                low_limit = tcf_pkg::UNDER_T;
                high_limit = tcf_pkg::OVER_T;
            end
            tcf_pkg::TCF_TYPE_B: begin
                low_limit = tcf_pkg::UNDER_B;
                high_limit = tcf_pkg::OVER_B;
            end
            tcf_pkg::TCF_TYPE_E: begin
                low_limit = tcf_pkg::UNDER_E;
                high_limit = tcf_pkg::OVER_E;
            end
            default: begin
                low_limit = tcf_pkg::UNDER_R;
                high_limit = tcf_pkg::OVER_R;
            end
        endcase
    end

    // at or below the low end, at or above the high end
    assign under_out = (temp_in <= low_limit);
    assign over_out = (temp_in >= high_limit);
endmodule : tcf_range_check
`default_nettype wire

// ===== rtl/tcf_scan_word.sv
// thermocouple scan word formatter: per-channel store, word build, byte readout
`timescale 1ns/10ps
`default_nettype none
module tcf_scan_word #(
    parameter int NUM_CHANNELS = tcf_pkg::NUM_CHANNELS
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // controller byte reads
    input wire logic rd_strobe_in,
    input wire logic [1:0] rd_byte_sel_in,
    output logic [7:0] rd_data_out,
    // conversion results
    input wire logic sample_wr_in,
    input wire logic [2:0] sample_chan_in,
    input wire logic signed [12:0] sample_temp_in,
    input wire logic sample_open_in,
    // board status and configuration
    input wire logic signed [7:0] cj_temp_in,
    input wire logic board_ok_in,
    input wire logic [2:0] tc_type_in,
    input wire logic fmt_twos_in,
    // state
    output logic [2:0] chan_ptr_out
);
    // the pointer wraps by overflow, so only a power-of-two count of eight is served
    if (NUM_CHANNELS != (1 << tcf_pkg::CHAN_W)) begin : g_bad_channels
        $error("tcf_scan_word: channel count must be 8");
    end

    logic signed [12:0] temp_mem [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] open_mem;
    logic [NUM_CHANNELS-1:0] loaded;
    logic [2:0] chan_ptr;
    logic heartbeat;
    logic [31:0] word;

    // read decode
    wire word_start = rd_strobe_in && (rd_byte_sel_in == tcf_pkg::BYTE_FIRST);
    wire word_done = rd_strobe_in && (rd_byte_sel_in == tcf_pkg::BYTE_LAST);

    // fields of the channel being reported
    // unloaded slots report zero so no unknown ever reaches the bus
    wire signed [12:0] cur_temp = loaded[chan_ptr] ? temp_mem[chan_ptr] : 13'sh0000;
    wire cur_open = loaded[chan_ptr] && open_mem[chan_ptr];
    wire cur_neg = cur_temp[12];
    wire [12:0] abs_temp = cur_neg ? 13'(-cur_temp) : 13'(cur_temp);
    wire [11:0] magnitude = abs_temp[12] ? tcf_pkg::MAG_MAX : abs_temp[11:0];
    wire cj_ok = (cj_temp_in >= tcf_pkg::CJ_MIN_C) && (cj_temp_in <= tcf_pkg::CJ_MAX_C);
    // a write landing on the reported channel in the latch cycle means the slot is mid-update
    wire updating = sample_wr_in && (sample_chan_in == chan_ptr);
    wire cur_valid = cj_ok && !updating && loaded[chan_ptr];
    wire cur_under;
    wire cur_over;

    // limits follow the type code; codes 6 and 7 both act as the last type
    tcf_range_check u_range (
        .tc_type_in(tc_type_in),
        .temp_in(cur_temp),
        .under_out(cur_under),
        .over_out(cur_over)
    );

    function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] sel);
        pick_byte = w[{sel, 3'b000} +: 8];
    endfunction : pick_byte

    logic [31:0] next_word;
    always_comb begin
        next_word = '0;
        next_word[tcf_pkg::POS_CHAN +: tcf_pkg::CHAN_W] = chan_ptr;
        next_word[tcf_pkg::POS_VALID] = cur_valid;
        next_word[tcf_pkg::POS_OPEN] = cur_open;
        next_word[tcf_pkg::POS_BOARD_OK] = board_ok_in;
        next_word[tcf_pkg::POS_UNDER] = cur_under;
        next_word[tcf_pkg::POS_OVER] = cur_over;
        next_word[tcf_pkg::POS_HEARTBEAT] = heartbeat;
        if (fmt_twos_in) begin
            next_word[tcf_pkg::POS_DATA +: tcf_pkg::DATA_W] = cur_temp[11:0];
            next_word[tcf_pkg::POS_EXT +: tcf_pkg::EXT_W] = {4{cur_neg}};
        end else begin
            next_word[tcf_pkg::POS_DATA +: tcf_pkg::DATA_W] = magnitude;
            next_word[tcf_pkg::POS_SIGN] = cur_neg;
        end
    end

    wire [31:0] out_word = word_start ? next_word : word;

    // conversion store; does not touch the pointer
    always_ff @(posedge clk_in) begin
        if (sample_wr_in) begin
            temp_mem[sample_chan_in] <= sample_temp_in;
            open_mem[sample_chan_in] <= sample_open_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            loaded <= '0;
        end else if (sample_wr_in) begin
            loaded[sample_chan_in] <= 1'b1;
        end
    end

    // word is frozen at the first byte so all four bytes agree
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            word <= '0;
            rd_data_out <= '0;
        end else if (rd_strobe_in) begin
            word <= out_word;
            rd_data_out <= pick_byte(out_word, rd_byte_sel_in);
        end
    end

    // heartbeat flips with the pointer so every word differs from the one before
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            chan_ptr <= tcf_pkg::CHAN_RESET;
            heartbeat <= 1'b0;
        end else if (word_done) begin
            chan_ptr <= chan_ptr + 3'h1;
            heartbeat <= !heartbeat;
        end
    end

    assign chan_ptr_out = chan_ptr;

    // most checks look at the latched word one edge after the first byte

    a_chan_field: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        word_start |=> (rd_data_out[2:0] == $past(chan_ptr)) && (rd_data_out[7:3] == 5'h00))
        else $error("channel byte wrong");
    a_ptr_advance: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        word_done |=> chan_ptr == 3'($past(chan_ptr) + 3'h1))
        else $error("pointer did not step");
    a_ptr_only_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !word_done |=> $stable(chan_ptr))
        else $error("pointer moved without read");
    a_ptr_wraps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (word_done && chan_ptr == 3'h7) |=> chan_ptr == 3'h0)
        else $error("pointer failed to wrap");
    a_heartbeat_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        word_done |=> heartbeat != $past(heartbeat))
        else $error("heartbeat did not toggle");
    a_valid_cj: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (word_start && !cj_ok) |=> !word[tcf_pkg::POS_VALID])
        else $error("valid set with cold junction out of range");
    a_valid_update: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (word_start && updating) |=> !word[tcf_pkg::POS_VALID])
        else $error("valid set during update");
    a_unused_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        word_start |=> !word[tcf_pkg::POS_UNUSED])
        else $error("unused bit set");
    a_sign_format: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (word_start && fmt_twos_in) |=> !word[tcf_pkg::POS_SIGN])
        else $error("sign bit set in twos format");
    a_ext_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (word_start && fmt_twos_in) |=> word[31:28] == {4{$past(cur_neg)}})
        else $error("sign extension wrong");
    a_board_ok: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        word_start |=> word[tcf_pkg::POS_BOARD_OK] == $past(board_ok_in))
        else $error("board ok bit wrong");
    a_byte_lane: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_strobe_in |=> rd_data_out == pick_byte(word, $past(rd_byte_sel_in)))
        else $error("byte lane mismatch");
    a_open_field: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        word_start |=> word[tcf_pkg::POS_OPEN] == $past(loaded[chan_ptr] && open_mem[chan_ptr]))
        else $error("open flag from wrong channel");
    a_valid_good: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (word_start && cj_ok && !updating && loaded[chan_ptr]) |=> word[tcf_pkg::POS_VALID])
        else $error("valid low with good data");
    a_range_exclusive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        word_start |=> !(word[tcf_pkg::POS_UNDER] && word[tcf_pkg::POS_OVER]))
        else $error("under and over both set");
    a_data_twos: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (word_start && fmt_twos_in) |=> word[tcf_pkg::POS_DATA +: tcf_pkg::DATA_W] == $past(cur_temp[11:0]))
        else $error("twos data field wrong");
    a_mag_ext_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (word_start && !fmt_twos_in) |=> word[tcf_pkg::POS_EXT +: tcf_pkg::EXT_W] == 4'h0)
        else $error("sign bits set in sign magnitude");
    a_mag_sign: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (word_start && !fmt_twos_in) |=> word[tcf_pkg::POS_SIGN] == $past(cur_neg))
        else $error("sign bit wrong in sign magnitude");

    c_full_word: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        word_start ##1 rd_strobe_in ##1 rd_strobe_in ##1 word_done);
    c_wrap: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        word_done && chan_ptr == 3'h7);
    c_update_hit: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        word_start && updating);
    c_twos_negative: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        word_start && fmt_twos_in && cur_neg);
    c_open_reported: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        word_start && cur_open);
endmodule : tcf_scan_word
`default_nettype wire
